// File: rtl/i2c_collision_cfg.svh
// Register map, field positions and reset values of the collision block.
// Assumes it is included by bare name from every design file except the package.
`ifndef I2C_COLLISION_CFG_SVH
`define I2C_COLLISION_CFG_SVH

// Register word addresses
`define ADDR_CTRL  2'h0
`define ADDR_BAUD  2'h1
`define ADDR_BUF   2'h2
`define ADDR_STAT  2'h3

// Control register fields
`define CTL_EN     0
`define CTL_SEN    1
`define CTL_RSEN   2
`define CTL_PEN    3
`define CTL_ACKEN  4
`define CTL_ACKDT  5

// Port status register fields
`define STA_BF     0
`define STA_START  1
`define STA_STOP   2
`define STA_BCL    3
`define STA_EVT    4
`define STA_FREE   5

`define BAUD_MSB   6
`define LAST_BIT   4'h8
`define BIT_STEP   4'h1
`define FIRST_BIT  4'h0
`define RD_IDLE    8'h00
`define SYNC_IDLE  2'h3
`define CNT_ZERO   7'h00
`define CNT_STEP   7'h01

`endif

// File: rtl/i2c_collision_pkg.sv
// Types shared by the collision block and its helpers.
// Assumes the configuration header is compiled alongside.
package i2c_collision_pkg;

  typedef enum logic [13:0] {
    ST_IDLE   = 14'h0001,
    ST_START1 = 14'h0002,
    ST_START2 = 14'h0004,
    ST_RS1    = 14'h0008,
    ST_RS2    = 14'h0010,
    ST_RS3    = 14'h0020,
    ST_RS4    = 14'h0040,
    ST_RS5    = 14'h0080,
    ST_SP1    = 14'h0100,
    ST_SP2    = 14'h0200,
    ST_SP3    = 14'h0400,
    ST_SP4    = 14'h0800,
    ST_BITLO  = 14'h1000,
    ST_BITHI  = 14'h2000
  } fsm_t;

  typedef struct packed {
    fsm_t       state;
    logic       sdaDrv;
    logic       sclDrv;
    logic       en;
    logic       sen;
    logic       rsen;
    logic       pen;
    logic       acken;
    logic       ackdt;
    logic [6:0] baud;
    logic [7:0] txBuf;
    logic [7:0] shift;
    logic [7:0] rdData;
    logic [3:0] bitCnt;
    logic       bf;
    logic       bcl;
    logic       evt;
    logic       startSeen;
    logic       stopSeen;
    logic       ackMode;
    logic       armed;
    logic       sdaPrev;
    logic       sclPrev;
  } core_t;

  typedef struct packed {
    logic [6:0] cnt;
    logic       run;
  } counter_t;

  typedef struct packed {
    logic [1:0] s1;
    logic [1:0] s2;
    logic [1:0] s3;
    logic [1:0] out;
  } sync_t;

endpackage

// File: rtl/pin_sync.sv
// Three-stage synchroniser for the SDA and SCL input levels.
// Assumes asynchronous pin inputs; output changes once stages two and three agree.
`timescale 1ns/1ps
`include "i2c_collision_cfg.svh"
module pin_sync
  import i2c_collision_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       nrst,
  input  wire logic [1:0] pinIn,
  output logic      [1:0] pinOut
);

  sync_t      s_ff;
  sync_t      nxt_s;
  logic [1:0] agree;

  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : g_bit
      assign agree[g] = s_ff.s2[g] ~^ s_ff.s3[g];
    end
  endgenerate

  always_comb
  begin
    nxt_s     = s_ff;
    nxt_s.s1  = pinIn;
    nxt_s.s2  = s_ff.s1;
    nxt_s.s3  = s_ff.s2;
    // A one-sample glitch never reaches the core
    nxt_s.out = (s_ff.out & ~agree) | (s_ff.s3 & agree);
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      s_ff <= '{s1: `SYNC_IDLE, s2: `SYNC_IDLE, s3: `SYNC_IDLE, out: `SYNC_IDLE};
    else
      s_ff <= nxt_s;
  end

  assign pinOut = s_ff.out;

endmodule

// File: rtl/bit_period_counter.sv
// Bit-period down counter reloaded from the baud reload value.
// Assumes load is a one-cycle request; done pulses for one cycle when a running count reaches zero.
`timescale 1ns/1ps
`include "i2c_collision_cfg.svh"
module bit_period_counter
  import i2c_collision_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       nrst,
  input  wire logic       load,
  input  wire logic [6:0] reload,
  output logic            done
);

  counter_t s_ff;
  counter_t nxt_s;

  always_comb
  begin
    nxt_s = s_ff;
    if (load)
    begin
      nxt_s.cnt = reload;
      nxt_s.run = 1'b1;
    end
    else if (s_ff.run && s_ff.cnt != `CNT_ZERO)
      nxt_s.cnt = 7'(s_ff.cnt - `CNT_STEP);
    else
      nxt_s.run = 1'b0;
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      s_ff <= '{cnt: `CNT_ZERO, run: 1'b0};
    else
      s_ff <= nxt_s;
  end

  // Single pulse: the counter stops in the cycle after it reports zero
  assign done = s_ff.run && (s_ff.cnt == `CNT_ZERO);

endmodule

// File: rtl/i2c_master_bus_collision.sv
// Multi-master arbitration and collision logic of a two-wire master.
// Assumes open-drain SDA/SCL pins resolved outside and a plain register port.
`timescale 1ns/1ps
`include "i2c_collision_cfg.svh"
// Contract
// - Released one read low while SCL high: collide
// - Byte collision: stop, clear full, release lines
// - Condition collision: abort, release, clear enable bit
// - After collision watch bus, STOP sets event
// - Buffer write restarts at first data bit
// - Bus free: stop seen, or neither seen
// - Line low at START begin: collide, idle
// - START: SDA high, load counter, count down
// - SCL low in first START count: collide
// - SDA low in first count: drive early
// - Second START count ignores SCL, then SCL low
// - Repeated START: SCL high, SDA low collides
// - Early SDA fall in repeated count harmless
// - SCL falls before our SDA low: collide
// - Both high: SDA low, count, SCL low
// - STOP: after count SDA low collides
// - STOP: SCL low before SDA release collides
// - Start/stop seen cleared by reset, disable
module i2c_master_bus_collision
  import i2c_collision_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       nrst,
  input  wire logic [1:0] regAddr,
  input  wire logic [7:0] regWrData,
  input  wire logic       regWr,
  input  wire logic       regRd,
  output logic      [7:0] regRdData,
  input  wire logic       sdaIn,
  output logic            sdaOut,
  output logic            sdaOe,
  input  wire logic       sclIn,
  output logic            sclOut,
  output logic            sclOe
);

  core_t      s_ff;
  core_t      nxt_s;
  logic [1:0] rstSync_ff;
  logic       rstSyncN;
  logic [1:0] pinSynced;
  logic       sdaS;
  logic       sclS;
  logic       cntLoad;
  logic       cntDone;
  logic       coll;
  logic       bufWr;
  logic       bitLast;
  logic       busFree;
  logic       stopNow;
  logic       startNow;
  logic       bclClr;

  // Reset is released synchronously so no flop leaves reset a cycle apart
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      rstSync_ff <= 2'h0;
    else
      rstSync_ff <= {rstSync_ff[0], 1'b1};
  end
  assign rstSyncN = rstSync_ff[1];

  pin_sync u_sync (
    .core_clk (core_clk),
    .nrst     (rstSyncN),
    .pinIn    ({sdaIn, sclIn}),
    .pinOut   (pinSynced)
  );
  assign sdaS = pinSynced[1];
  assign sclS = pinSynced[0];

  bit_period_counter u_cnt (
    .core_clk (core_clk),
    .nrst     (rstSyncN),
    .load     (cntLoad),
    .reload   (s_ff.baud),
    .done     (cntDone)
  );

  assign bufWr    = regWr && (regAddr == `ADDR_BUF);
  assign bclClr   = regWr && (regAddr == `ADDR_STAT) && regWrData[`STA_BCL];
  assign bitLast  = !s_ff.ackMode && (s_ff.bitCnt == `LAST_BIT);
  assign busFree  = s_ff.stopSeen || (!s_ff.startSeen && !s_ff.stopSeen);
  assign startNow = s_ff.en && sclS && s_ff.sclPrev && s_ff.sdaPrev && !sdaS;
  assign stopNow  = s_ff.en && sclS && s_ff.sclPrev && !s_ff.sdaPrev && sdaS;

  always_comb
  begin
    nxt_s        = s_ff;
    cntLoad      = 1'b0;
    coll         = 1'b0;
    nxt_s.rdData = `RD_IDLE;
    nxt_s.sdaPrev = sdaS;
    nxt_s.sclPrev = sclS;

    // Software writes come first so that hardware sets below win
    if (regWr)
    begin
      case (regAddr)
        `ADDR_CTRL:
        begin
          nxt_s.en    = regWrData[`CTL_EN];
          nxt_s.sen   = regWrData[`CTL_SEN];
          nxt_s.rsen  = regWrData[`CTL_RSEN];
          nxt_s.pen   = regWrData[`CTL_PEN];
          nxt_s.acken = regWrData[`CTL_ACKEN];
          nxt_s.ackdt = regWrData[`CTL_ACKDT];
        end
        `ADDR_BAUD: nxt_s.baud = regWrData[`BAUD_MSB:0];
        `ADDR_STAT:
        begin
          if (regWrData[`STA_BCL])
            nxt_s.bcl = 1'b0;
          if (regWrData[`STA_EVT])
            nxt_s.evt = 1'b0;
        end
        default: ;
      endcase
    end

    if (regRd)
    begin
      case (regAddr)
        `ADDR_CTRL: nxt_s.rdData = {2'h0, s_ff.ackdt, s_ff.acken, s_ff.pen,
                                    s_ff.rsen, s_ff.sen, s_ff.en};
        `ADDR_BAUD: nxt_s.rdData = {1'b0, s_ff.baud};
        `ADDR_BUF:  nxt_s.rdData = s_ff.txBuf;
        default:    nxt_s.rdData = {2'h0, busFree, s_ff.evt, s_ff.bcl,
                                    s_ff.stopSeen, s_ff.startSeen, s_ff.bf};
      endcase
    end

    // Bus watcher keeps running in every state while enabled, collision or not
    if (startNow)
    begin
      nxt_s.startSeen = 1'b1;
      nxt_s.stopSeen  = 1'b0;
    end
    if (stopNow)
    begin
      nxt_s.stopSeen  = 1'b1;
      nxt_s.startSeen = 1'b0;
      nxt_s.evt       = 1'b1;
    end

    unique case (s_ff.state)
      ST_IDLE:
      begin
        if (!s_ff.en)
          nxt_s.state = ST_IDLE;
        else if (s_ff.sen)
        begin
          if (!sdaS || !sclS)
            coll = 1'b1;
          else
          begin
            cntLoad     = 1'b1;
            nxt_s.state = ST_START1;
          end
        end
        else if (s_ff.rsen)
        begin
          nxt_s.sdaDrv = 1'b0;
          nxt_s.sclDrv = 1'b1;
          nxt_s.state  = ST_RS1;
        end
        else if (s_ff.pen)
        begin
          nxt_s.sdaDrv = 1'b1;
          nxt_s.state  = ST_SP1;
        end
        else if (s_ff.acken)
        begin
          nxt_s.ackMode = 1'b1;
          nxt_s.shift   = {s_ff.ackdt, 7'h00};
          nxt_s.bitCnt  = `FIRST_BIT;
          nxt_s.sclDrv  = 1'b1;
          cntLoad       = 1'b1;
          nxt_s.state   = ST_BITLO;
        end
        else if (bufWr)
        begin
          // Always from the top bit, whatever a lost transfer had reached
          nxt_s.txBuf   = regWrData;
          nxt_s.shift   = regWrData;
          nxt_s.bitCnt  = `FIRST_BIT;
          nxt_s.bf      = 1'b1;
          nxt_s.ackMode = 1'b0;
          nxt_s.sclDrv  = 1'b1;
          cntLoad       = 1'b1;
          nxt_s.state   = ST_BITLO;
        end
      end
      ST_START1:
      begin
        if (sdaS && !sclS)
          coll = 1'b1;
        else if (!sdaS || cntDone)
        begin
          // Another master already went low: follow it, no collision
          nxt_s.sdaDrv = 1'b1;
          cntLoad      = 1'b1;
          nxt_s.state  = ST_START2;
        end
      end
      ST_START2:
      begin
        if (cntDone)
        begin
          nxt_s.sclDrv = 1'b1;
          nxt_s.sen    = 1'b0;
          nxt_s.evt    = 1'b1;
          nxt_s.state  = ST_IDLE;
        end
      end
      ST_RS1:
      begin
        if (sdaS)
        begin
          cntLoad     = 1'b1;
          nxt_s.state = ST_RS2;
        end
      end
      ST_RS2:
      begin
        if (cntDone)
        begin
          nxt_s.sclDrv = 1'b0;
          nxt_s.state  = ST_RS3;
        end
      end
      ST_RS3:
      begin
        if (sclS && !sdaS)
          coll = 1'b1;
        else if (sclS)
        begin
          cntLoad     = 1'b1;
          nxt_s.state = ST_RS4;
        end
      end
      ST_RS4:
      begin
        // SDA falling here is another START, not a loss
        if (!sclS)
          coll = 1'b1;
        else if (cntDone)
        begin
          nxt_s.sdaDrv = 1'b1;
          cntLoad      = 1'b1;
          nxt_s.state  = ST_RS5;
        end
      end
      ST_RS5:
      begin
        if (cntDone)
        begin
          nxt_s.sclDrv = 1'b1;
          nxt_s.rsen   = 1'b0;
          nxt_s.evt    = 1'b1;
          nxt_s.state  = ST_IDLE;
        end
      end
      ST_SP1:
      begin
        if (!sdaS)
        begin
          nxt_s.sclDrv = 1'b0;
          nxt_s.state  = ST_SP2;
        end
      end
      ST_SP2:
      begin
        if (sclS)
        begin
          cntLoad     = 1'b1;
          nxt_s.state = ST_SP3;
        end
      end
      ST_SP3:
      begin
        if (!sclS)
          coll = 1'b1;
        else if (cntDone)
        begin
          nxt_s.sdaDrv = 1'b0;
          cntLoad      = 1'b1;
          nxt_s.state  = ST_SP4;
        end
      end
      ST_SP4:
      begin
        if (cntDone && !sdaS)
          coll = 1'b1;
        else if (cntDone)
        begin
          nxt_s.pen   = 1'b0;
          nxt_s.evt   = 1'b1;
          nxt_s.state = ST_IDLE;
        end
      end
      ST_BITLO:
      begin
        nxt_s.sdaDrv = !bitLast && !s_ff.shift[7];
        if (cntDone)
        begin
          nxt_s.sclDrv = 1'b0;
          nxt_s.armed  = 1'b0;
          nxt_s.state  = ST_BITHI;
        end
      end
      default: // ST_BITHI
      begin
        // The acknowledge slot of a byte belongs to the slave
        if (sclS && !s_ff.sdaDrv && !sdaS && !bitLast)
          coll = 1'b1;
        else if (sclS && !s_ff.armed)
        begin
          cntLoad     = 1'b1;
          nxt_s.armed = 1'b1;
        end
        else if (s_ff.armed && cntDone)
        begin
          nxt_s.sclDrv = 1'b1;
          if (s_ff.ackMode || bitLast)
          begin
            nxt_s.acken   = s_ff.ackMode ? 1'b0 : s_ff.acken;
            nxt_s.bf      = 1'b0;
            nxt_s.ackMode = 1'b0;
            nxt_s.evt     = 1'b1;
            nxt_s.state   = ST_IDLE;
          end
          else
          begin
            nxt_s.shift  = {s_ff.shift[6:0], 1'b0};
            nxt_s.bitCnt = 4'(s_ff.bitCnt + `BIT_STEP);
            cntLoad      = 1'b1;
            nxt_s.state  = ST_BITLO;
          end
        end
      end
    endcase

    if (coll)
    begin
      nxt_s.bcl     = 1'b1;
      nxt_s.sdaDrv  = 1'b0;
      nxt_s.sclDrv  = 1'b0;
      nxt_s.bf      = 1'b0;
      nxt_s.sen     = 1'b0;
      nxt_s.rsen    = 1'b0;
      nxt_s.pen     = 1'b0;
      nxt_s.acken   = 1'b0;
      nxt_s.ackMode = 1'b0;
      nxt_s.armed   = 1'b0;
      nxt_s.state   = ST_IDLE;
    end

    if (!nxt_s.en)
    begin
      nxt_s.startSeen = 1'b0;
      nxt_s.stopSeen  = 1'b0;
      nxt_s.sdaDrv    = 1'b0;
      nxt_s.sclDrv    = 1'b0;
      nxt_s.state     = ST_IDLE;
    end
  end

  always_ff @(posedge core_clk or negedge rstSyncN)
  begin
    if (!rstSyncN)
      s_ff <= '{state: ST_IDLE, default: '0};
    else
      s_ff <= nxt_s;
  end

  assign regRdData = s_ff.rdData;
  assign sdaOut    = 1'b0;
  assign sclOut    = 1'b0;
  assign sdaOe     = s_ff.sdaDrv;
  assign sclOe     = s_ff.sclDrv;

  property p_bit_lost;
    @(posedge core_clk) disable iff (!rstSyncN)
    (s_ff.state == ST_BITHI && s_ff.en && !regWr && sclS && !s_ff.sdaDrv && !sdaS
     && !bitLast) |=> (s_ff.bcl && s_ff.state == ST_IDLE);
  endproperty
  a_bit_lost: assert property (p_bit_lost)
    else $error("arbitration loss not flagged");

  property p_byte_release;
    @(posedge core_clk) disable iff (!rstSyncN)
    (s_ff.state == ST_BITHI && s_ff.en && !regWr && sclS && !s_ff.sdaDrv && !sdaS
     && !bitLast) |=> (!s_ff.bf && !sdaOe && !sclOe)[*2];
  endproperty
  a_byte_release: assert property (p_byte_release)
    else $error("lines or full flag not released after byte loss");

  property p_stop_scl;
    @(posedge core_clk) disable iff (!rstSyncN)
    (s_ff.state == ST_SP3 && s_ff.en && !regWr && !sclS)
      |=> (s_ff.bcl && !s_ff.pen && !sdaOe && !sclOe);
  endproperty
  a_stop_scl: assert property (p_stop_scl)
    else $error("stop clock loss not handled");

  property p_start_busy;
    @(posedge core_clk) disable iff (!rstSyncN)
    (s_ff.state == ST_IDLE && s_ff.en && s_ff.sen && !regWr && (!sdaS || !sclS))
      |=> (s_ff.bcl && !s_ff.sen && s_ff.state == ST_IDLE);
  endproperty
  a_start_busy: assert property (p_start_busy)
    else $error("start on busy lines not aborted");

  property p_start_scl;
    @(posedge core_clk) disable iff (!rstSyncN)
    (s_ff.state == ST_START1 && s_ff.en && !regWr && sdaS && !sclS) |=> s_ff.bcl;
  endproperty
  a_start_scl: assert property (p_start_scl)
    else $error("clock low in first start count not flagged");

  property p_start_early;
    @(posedge core_clk) disable iff (!rstSyncN)
    (s_ff.state == ST_START1 && s_ff.en && !regWr && !sdaS && sclS)
      |=> (sdaOe && s_ff.state == ST_START2 && $stable(s_ff.bcl));
  endproperty
  a_start_early: assert property (p_start_early)
    else $error("early start data not followed");

  property p_stop_event;
    @(posedge core_clk) disable iff (!rstSyncN)
    stopNow |=> (s_ff.evt && s_ff.stopSeen && busFree);
  endproperty
  a_stop_event: assert property (p_stop_event)
    else $error("stop on bus did not raise event");

  property p_bcl_sticky;
    @(posedge core_clk) disable iff (!rstSyncN)
    (s_ff.bcl && !bclClr) |=> s_ff.bcl;
  endproperty
  a_bcl_sticky: assert property (p_bcl_sticky)
    else $error("collision flag dropped without software clear");

  property p_rs_data_low;
    @(posedge core_clk) disable iff (!rstSyncN)
    (s_ff.state == ST_RS3 && s_ff.en && !regWr && sclS && !sdaS)
      |=> (s_ff.bcl && !s_ff.rsen);
  endproperty
  a_rs_data_low: assert property (p_rs_data_low)
    else $error("repeated start data loss not flagged");

  property p_rs_finish;
    @(posedge core_clk) disable iff (!rstSyncN)
    (s_ff.state == ST_RS5 && s_ff.en && !regWr && cntDone)
      |=> (sclOe && sdaOe && !s_ff.rsen);
  endproperty
  a_rs_finish: assert property (p_rs_finish)
    else $error("repeated start not completed");

endmodule

// File: tb/bus_partner.sv
// Other masters and slaves sharing the two-wire bus, with pull-ups on both lines.
// Assumes the bench asks for holds, and for a foreign clock only within frames.
`timescale 1ns/1ps
module bus_partner
(
  input  wire logic sdaOe,
  input  wire logic sclOe,
  input  wire logic holdSda,
  input  wire logic holdScl,
  input  wire logic runClk,
  output logic      sdaLine,
  output logic      sclLine
);
  logic otherScl;

  // Foreign master clock, 400 ns period, parked high outside frames
  initial
  begin
    otherScl = 1'b1;
    #7;
    forever
    begin
      #200;
      otherScl = runClk ? ~otherScl : 1'b1;
    end
  end

  // Wired-AND: a released line floats high
  assign sdaLine = ~(sdaOe | holdSda);
  assign sclLine = ~(sclOe | holdScl) & otherScl;
endmodule

// File: tb/testbench.sv
// Self-checking bench for the collision block against a bus-level model.
// Assumes the partner resolves the open-drain lines and the register port never stalls.
`timescale 1ns/1ps
`include "i2c_collision_cfg.svh"
module testbench;
  import i2c_collision_pkg::*;
  logic        core_clk;
  logic        nrst;
  logic [1:0]  regAddr;
  logic [7:0]  regWrData;
  logic        regWr;
  logic        regRd;
  logic [7:0]  regRdData;
  logic        sdaIn, sdaOut, sdaOe, sclIn, sclOut, sclOe;
  logic        holdSda, holdScl, runClk;
  logic        prevSda, prevScl;
  logic [31:0] lfsrState;
  logic [31:0] rv;
  logic [6:0]  baud;
  int          failures, checks, cycles, n;
  int          mBf, mStart, mStop, mBcl, mEvt;

  i2c_master_bus_collision uut (.core_clk(core_clk), .nrst(nrst), .regAddr(regAddr),
    .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
    .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe), .sclIn(sclIn), .sclOut(sclOut),
    .sclOe(sclOe));

  bus_partner other (.sdaOe(sdaOe), .sclOe(sclOe), .holdSda(holdSda), .holdScl(holdScl),
    .runClk(runClk), .sdaLine(sdaIn), .sclLine(sclIn));

  initial
  begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  // Bus watcher: START and STOP seen on the wires
  always @(posedge core_clk)
  begin
    if (prevScl && sclIn && prevSda !== sdaIn)
    begin
      mStart = int'(!sdaIn);
      mStop = int'(sdaIn);
      if (sdaIn)
        mEvt = 1;
    end
    prevSda = sdaIn;
    prevScl = sclIn;
  end

  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      failures++;
      conclude();
    end
  end

  function automatic logic [31:0] lfsrNext();
    lfsrState = {lfsrState[30:0], lfsrState[31] ^ lfsrState[21] ^ lfsrState[1] ^ lfsrState[0]};
    return lfsrState;
  endfunction

  function automatic logic [7:0] expStat();
    logic freeBus;
    freeBus = (mStop != 0) || (mStart == 0);
    return {2'b00, freeBus, mEvt[0], mBcl[0], mStop[0], mStart[0], mBf[0]};
  endfunction

  task automatic idle(input int k);
    repeat (k) @(posedge core_clk);
  endtask

  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge core_clk);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge core_clk);
    regWr <= 1'b0;
  endtask

  task automatic rd(input logic [1:0] a, output logic [7:0] d);
    @(posedge core_clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge core_clk);
    regRd <= 1'b0;
    #1;
    d = regRdData;
  endtask

  task automatic cmp(input logic [7:0] got, input logic [7:0] exp, input string what);
    checks++;
    if (got !== exp)
    begin
      failures++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic chkReg(input logic [1:0] a, input logic [7:0] exp, input string what);
    logic [7:0] v;
    rd(a, v);
    cmp(v, exp, what);
  endtask

  task automatic rng(input int got, input int lo, input int hi, input string what);
    checks++;
    if (got < lo || got > hi)
    begin
      failures++;
      $display("wrong value at %0t: %s took %0d cycles", $time, what, got);
    end
  endtask

  // Counts cycles until a line enable reaches a level, bounded
  task automatic waitOe(input logic onScl, input logic lvl, output int k);
    k = 0;
    do
    begin
      @(posedge core_clk);
      #1;
      k++;
    end
    while (((onScl ? sclOe : sdaOe) !== lvl) && k < 500);
  endtask

  task automatic conclude();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  initial
  begin
    nrst = 1'b0;
    regAddr = 2'h0;
    regWrData = 8'h00;
    regWr = 1'b0;
    regRd = 1'b0;
    holdSda = 1'b0;
    holdScl = 1'b0;
    runClk = 1'b0;
    prevSda = 1'b1;
    prevScl = 1'b1;
    lfsrState = 32'h2231EB7D;
    {failures, checks, cycles, mBf, mStart, mStop, mBcl, mEvt} = '0;
    repeat (6) @(posedge core_clk);
    nrst <= 1'b1;
    idle(4);
    chkReg(`ADDR_CTRL, 8'h00, "ctrl after reset");
    cmp({6'h00, sclOut, sdaOut}, 8'h00, "open-drain levels");
    chkReg(`ADDR_STAT, expStat(), "status after reset");
    rv = lfsrNext();
    baud = 7'h03 + {5'h00, rv[1:0]};
    wr(`ADDR_BAUD, {1'b0, baud});
    chkReg(`ADDR_BAUD, {1'b0, baud}, "baud");
    wr(`ADDR_CTRL, 8'h01);
    // START requested while another party holds SDA low
    holdSda <= 1'b1;
    idle(8);
    wr(`ADDR_CTRL, 8'h03);
    idle(8);
    mBcl = 1;
    cmp({6'h00, sclOe, sdaOe}, 8'h00, "lines after start abort");
    chkReg(`ADDR_CTRL, 8'h01, "start enable after abort");
    chkReg(`ADDR_STAT, expStat(), "collision at start begin");
    holdSda <= 1'b0;
    idle(8);
    chkReg(`ADDR_STAT, expStat(), "stop seen after collision");
    wr(`ADDR_STAT, 8'h18);
    mBcl = 0;
    mEvt = 0;
    chkReg(`ADDR_STAT, expStat(), "flags cleared by software");
    // A foreign master pulls SCL low inside our first START count, then clocks it
    wr(`ADDR_CTRL, 8'h03);
    holdScl <= 1'b1;
    runClk <= 1'b1;
    idle(12);
    holdScl <= 1'b0;
    idle(12);
    runClk <= 1'b0;
    idle(12);
    mBcl = 1;
    cmp({7'h00, sdaOe}, 8'h00, "sda after scl collision");
    chkReg(`ADDR_STAT, expStat(), "scl low in start count");
    wr(`ADDR_STAT, 8'h08);
    mBcl = 0;
    // Fresh START on a free bus
    wr(`ADDR_CTRL, 8'h03);
    waitOe(1'b0, 1'b1, n);
    rng(n, baud + 1, baud + 12, "first start count");
    waitOe(1'b1, 1'b1, n);
    rng(n, baud + 1, baud + 4, "second start count");
    idle(8);
    mEvt = 1;
    chkReg(`ADDR_CTRL, 8'h01, "start enable done");
    chkReg(`ADDR_STAT, expStat(), "start complete");
    wr(`ADDR_STAT, 8'h10);
    mEvt = 0;
    // Released data one is overridden while SCL is high
    rv = lfsrNext();
    wr(`ADDR_BUF, {1'b1, rv[6:0]});
    mBf = 1;
    waitOe(1'b1, 1'b0, n);
    holdSda <= 1'b1;
    idle(10);
    mBcl = 1;
    mBf = 0;
    cmp({6'h00, sclOe, sdaOe}, 8'h00, "lines after byte collision");
    chkReg(`ADDR_STAT, expStat(), "byte collision");
    holdSda <= 1'b0;
    idle(8);
    chkReg(`ADDR_STAT, expStat(), "stop watched after byte loss");
    wr(`ADDR_STAT, 8'h18);
    mBcl = 0;
    mEvt = 0;
    // New byte restarts at its first bit, a zero that must be driven
    wr(`ADDR_BUF, {1'b0, rv[14:8]});
    mBf = 1;
    idle(2);
    #1;
    cmp({6'h00, sclOe, sdaOe}, 8'h03, "first data bit driven");
    idle(600);
    mBf = 0;
    mEvt = 1;
    chkReg(`ADDR_STAT, expStat(), "byte finished");
    wr(`ADDR_STAT, 8'h10);
    mEvt = 0;
    // STOP while another party keeps SDA low
    wr(`ADDR_CTRL, 8'h09);
    holdSda <= 1'b1;
    idle(60);
    mBcl = 1;
    cmp({6'h00, sclOe, sdaOe}, 8'h00, "lines after stop abort");
    chkReg(`ADDR_CTRL, 8'h01, "stop enable after abort");
    holdSda <= 1'b0;
    idle(8);
    chkReg(`ADDR_STAT, expStat(), "stop collision");
    wr(`ADDR_STAT, 8'h18);
    mBcl = 0;
    mEvt = 0;
    // Another master's START inside our first count: follow it early
    wr(`ADDR_BAUD, 8'h40);
    wr(`ADDR_CTRL, 8'h03);
    holdSda <= 1'b1;
    waitOe(1'b0, 1'b1, n);
    rng(n, 4, 8, "early start data");
    holdSda <= 1'b0;
    waitOe(1'b1, 1'b1, n);
    rng(n, 65, 68, "second count after early data");
    idle(8);
    mEvt = 1;
    chkReg(`ADDR_STAT, expStat(), "early start without collision");
    wr(`ADDR_STAT, 8'h10);
    mEvt = 0;
    wr(`ADDR_BAUD, {1'b0, baud});
    // Repeated START on a quiet bus runs to completion
    wr(`ADDR_CTRL, 8'h05);
    idle(80);
    mEvt = 1;
    cmp({6'h00, sclOe, sdaOe}, 8'h03, "lines after repeated start");
    chkReg(`ADDR_CTRL, 8'h01, "repeated start enable done");
    chkReg(`ADDR_STAT, expStat(), "repeated start complete");
    wr(`ADDR_STAT, 8'h10);
    mEvt = 0;
    // Repeated START that finds SDA held low once SCL is released
    wr(`ADDR_CTRL, 8'h05);
    waitOe(1'b1, 1'b0, n);
    holdSda <= 1'b1;
    idle(10);
    mBcl = 1;
    cmp({6'h00, sclOe, sdaOe}, 8'h00, "lines after repeated start loss");
    chkReg(`ADDR_CTRL, 8'h01, "repeated start enable after loss");
    holdSda <= 1'b0;
    idle(8);
    chkReg(`ADDR_STAT, expStat(), "repeated start collision");
    wr(`ADDR_STAT, 8'h18);
    mBcl = 0;
    mEvt = 0;
    // Released acknowledge overridden by another receiver's zero
    wr(`ADDR_CTRL, 8'h31);
    waitOe(1'b1, 1'b0, n);
    holdSda <= 1'b1;
    idle(10);
    mBcl = 1;
    cmp({6'h00, sclOe, sdaOe}, 8'h00, "lines after acknowledge loss");
    chkReg(`ADDR_CTRL, 8'h21, "acknowledge enable after loss");
    holdSda <= 1'b0;
    idle(8);
    chkReg(`ADDR_STAT, expStat(), "acknowledge collision");
    wr(`ADDR_STAT, 8'h18);
    mBcl = 0;
    mEvt = 0;
    wr(`ADDR_CTRL, 8'h00);
    mStart = 0;
    mStop = 0;
    chkReg(`ADDR_STAT, expStat(), "seen flags after disable");
    conclude();
  end
endmodule
